// >>> src/pdc_pkg.sv
// Package with register map, field layout, reset values and state codes for the power domain block
package pdc_pkg;
  localparam logic [11:0] PDC_OFS_STATUS1 = 12'h000;
  localparam logic [11:0] PDC_OFS_SETUP0 = 12'h004;
  localparam logic [11:0] PDC_OFS_GO = 12'h008;
  localparam int PDC_ADDR_W = 12;
  // Status field positions
  localparam int PDC_ST_EMU_BIT = 11;
  localparam int PDC_ST_DONE_BIT = 9;
  localparam int PDC_ST_POR_BIT = 8;
  localparam int PDC_ST_CODE_LSB = 0;
  localparam int PDC_ST_CODE_MSB = 4;
  // Setup field positions
  localparam int PDC_CT_WAKE_LSB = 16;
  localparam int PDC_CT_WAKE_MSB = 23;
  localparam int PDC_CT_MODE_LSB = 12;
  localparam int PDC_CT_MODE_MSB = 15;
  localparam int PDC_CT_IE_BIT = 9;
  localparam int PDC_CT_RSV1_BIT = 8;
  localparam int PDC_CT_NEXT_BIT = 0;
  // Go register fields
  localparam int PDC_GO_D0_BIT = 0;
  localparam int PDC_GO_D1_BIT = 1;
  localparam int PDC_GO_BUSY_BIT = 2;
  // Reset values
  localparam logic [7:0] PDC_WAKE_RST = 8'h1f;
  localparam logic [3:0] PDC_MODE_ON = 4'hf;
  localparam logic PDC_IE_RST = 1'b0;
  localparam logic PDC_NEXT_RST = 1'b1;
  // Domain state codes
  localparam logic [4:0] PDC_CODE_OFF = 5'h00;
  localparam logic [4:0] PDC_CODE_ON = 5'h01;
  localparam logic [4:0] PDC_CODE_UP = 5'h10;
  localparam logic [4:0] PDC_CODE_GOOD = 5'h11;
  localparam logic [4:0] PDC_CODE_DOWN = 5'h12;
  localparam logic [4:0] PDC_CODE_TR_MAX = 5'h1a;

  typedef enum logic [4:0] {
    PDC_ST_OFF = 5'b00001,
    PDC_ST_UP = 5'b00010,
    PDC_ST_GOOD = 5'b00100,
    PDC_ST_ON = 5'b01000,
    PDC_ST_DOWN = 5'b10000
  } pdc_dom_type;
endpackage : pdc_pkg

// >>> src/pdc_power_domain_status_control.sv
// Power domain 1 status and power domain 0 setup registers with an APB slave
//
// Notes on behaviour
// - Status bit 11 is 1 while emulation overrides the requested state.
// - Status bit 9 reads 1 once the domain reset sequence completed.
// - Status bit 8 reads 0 while domain reset asserted, 1 once released.
// - State code bits 4-0: 0 off, 1h on, 10h-1Ah in transition.
// - Wake delay field in setup bits 23-16 resets to 1Fh, writable.
// - Wake bits 19-16 time power-on to good; upper bits good to access.
// - Power-down mode bits 15-12 only support Fh; other codes are not taken.
// - Setup bit 9 enables the emulation override interrupt.
// - Setup bit 0 holds next state, 1 on, 0 off.
// - Next bit is read/write but domain 0 stays on always.
// - Writing 1 to go bit 1 moves domain 1 to its differing next state; go bit 0 has no effect.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pdc_power_domain_status_control
  import pdc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [PDC_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic emu_override_in,
  input wire logic domain1_next_in,
  output logic domain1_power_en_out,
  output logic domain1_por_n_out,
  output logic domain0_on_out,
  output logic emu_irq_out
);

  typedef struct packed {
    pdc_dom_type dom;
    logic [3:0] cnt;
    logic [7:0] wake;
    logic [3:0] mode;
    logic ie;
    logic next0;
    logic por;
    logic domain_reset_complete;
    logic emu;
    logic irq;
    logic d0on;
    logic pwr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pdc_state_type;

  localparam pdc_state_type PDC_STATE_RST = '{
    dom: PDC_ST_OFF,
    cnt: 4'h0,
    wake: PDC_WAKE_RST,
    mode: PDC_MODE_ON,
    ie: PDC_IE_RST,
    next0: PDC_NEXT_RST,
    por: 1'b0,
    domain_reset_complete: 1'b0,
    emu: 1'b0,
    irq: 1'b0,
    d0on: 1'b1,
    pwr: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

  pdc_state_type s;
  pdc_state_type next_s;

  logic [4:0] code;
  logic [31:0] status_word;
  logic [31:0] setup_word;
  logic [31:0] go_word;
  logic busy;
  logic acc_phase;
  logic wr_take;
  logic go1;

  always_comb begin
    case (s.dom)
      PDC_ST_OFF: code = PDC_CODE_OFF;
      PDC_ST_UP: code = PDC_CODE_UP;
      PDC_ST_GOOD: code = PDC_CODE_GOOD;
      PDC_ST_ON: code = PDC_CODE_ON;
      PDC_ST_DOWN: code = PDC_CODE_DOWN;
      default: code = PDC_CODE_OFF;
    endcase
  end

  assign busy = (s.dom != PDC_ST_OFF) && (s.dom != PDC_ST_ON);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[PDC_ST_EMU_BIT] = s.emu;
    status_word[PDC_ST_DONE_BIT] = s.domain_reset_complete;
    status_word[PDC_ST_POR_BIT] = s.por;
    status_word[PDC_ST_CODE_MSB:PDC_ST_CODE_LSB] = code;
  end

  always_comb begin
    setup_word = 32'h0000_0000;
    setup_word[PDC_CT_WAKE_MSB:PDC_CT_WAKE_LSB] = s.wake;
    setup_word[PDC_CT_MODE_MSB:PDC_CT_MODE_LSB] = s.mode;
    setup_word[PDC_CT_IE_BIT] = s.ie;
    setup_word[PDC_CT_RSV1_BIT] = 1'b1;
    setup_word[PDC_CT_NEXT_BIT] = s.next0;
  end

  always_comb begin
    go_word = 32'h0000_0000;
    go_word[PDC_GO_BUSY_BIT] = busy;
  end

  // Access phase answered one cycle late; write lands when pready is seen high
  assign acc_phase = psel_in && penable_in;
  assign wr_take = acc_phase && s.pready && pwrite_in;
  assign go1 = wr_take && (paddr_in == PDC_OFS_GO) && pwdata_in[PDC_GO_D1_BIT];

  always_comb begin
    next_s = s;
    next_s.pready = acc_phase && !s.pready;
    next_s.pslverr = 1'b0;
    if (acc_phase && !s.pready) begin
      if (paddr_in == PDC_OFS_STATUS1) begin
        next_s.prdata = pwrite_in ? 32'h0000_0000 : status_word;
      end else if (paddr_in == PDC_OFS_SETUP0) begin
        next_s.prdata = pwrite_in ? 32'h0000_0000 : setup_word;
      end else if (paddr_in == PDC_OFS_GO) begin
        next_s.prdata = pwrite_in ? 32'h0000_0000 : go_word;
      end else begin
        next_s.prdata = 32'h0000_0000;
        next_s.pslverr = 1'b1;
      end
    end
    if (wr_take && (paddr_in == PDC_OFS_SETUP0)) begin
      next_s.wake = pwdata_in[PDC_CT_WAKE_MSB:PDC_CT_WAKE_LSB];
      if (pwdata_in[PDC_CT_MODE_MSB:PDC_CT_MODE_LSB] == PDC_MODE_ON) begin
        next_s.mode = PDC_MODE_ON;
      end
      next_s.ie = pwdata_in[PDC_CT_IE_BIT];
      next_s.next0 = pwdata_in[PDC_CT_NEXT_BIT];
    end
    // Domain 1 power sequencing
    case (s.dom)
      PDC_ST_OFF: begin
        next_s.por = 1'b0;
        next_s.domain_reset_complete = 1'b0;
        next_s.pwr = 1'b0;
        if (go1 && domain1_next_in) begin
          next_s.dom = PDC_ST_UP;
          next_s.pwr = 1'b1;
          next_s.cnt = s.wake[3:0];
        end
      end
      PDC_ST_UP: begin
        if (s.cnt == 4'h0) begin
          next_s.dom = PDC_ST_GOOD;
          next_s.por = 1'b1;
          next_s.cnt = s.wake[7:4];
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      PDC_ST_GOOD: begin
        if (s.cnt == 4'h0) begin
          next_s.dom = PDC_ST_ON;
          next_s.domain_reset_complete = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      PDC_ST_ON: begin
        if (go1 && !domain1_next_in) begin
          next_s.dom = PDC_ST_DOWN;
          next_s.por = 1'b0;
          next_s.domain_reset_complete = 1'b0;
        end
      end
      PDC_ST_DOWN: begin
        next_s.dom = PDC_ST_OFF;
        next_s.pwr = 1'b0;
      end
      default: begin
        next_s.dom = PDC_ST_OFF;
      end
    endcase
    next_s.emu = emu_override_in;
    next_s.irq = next_s.emu && next_s.ie;
    // Always-on domain ignores the next-state bit
    next_s.d0on = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s <= PDC_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_out = s.prdata;
  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign domain1_power_en_out = s.pwr;
  assign domain1_por_n_out = s.por;
  assign domain0_on_out = s.d0on;
  assign emu_irq_out = s.irq;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_emu_flag: assert property (emu_override_in |=> s.emu)
    else $error("emulation flag not set after override");
  chk_emu_clear: assert property (!emu_override_in |=> !status_word[PDC_ST_EMU_BIT])
    else $error("emulation flag not cleared");
  chk_done_on: assert property ((s.dom == PDC_ST_ON) |-> (s.domain_reset_complete && s.por))
    else $error("domain on without reset done");
  chk_por_up: assert property ((s.dom == PDC_ST_UP) |-> !status_word[PDC_ST_POR_BIT])
    else $error("reset released too early");
  chk_code_legal: assert property ((code <= PDC_CODE_ON) || ((code >= PDC_CODE_UP) &&
    (code <= PDC_CODE_TR_MAX)))
    else $error("illegal state code");
  chk_wake_reset: assert property ($rose(rst_n_in) |-> (s.wake == PDC_WAKE_RST))
    else $error("wake delay reset value wrong");
  chk_up_time: assert property (($past(s.dom) == PDC_ST_OFF) && (s.dom == PDC_ST_UP) &&
    (s.wake[3:0] == 4'h2) |-> ##2 (s.dom == PDC_ST_UP) ##1 (s.dom == PDC_ST_GOOD))
    else $error("power-on to good delay wrong");
  chk_mode_fixed: assert property (s.mode == PDC_MODE_ON)
    else $error("power-down mode left the only legal code");
  chk_irq_gate: assert property ((emu_override_in && s.ie && !wr_take) |=> emu_irq_out)
    else $error("enabled interrupt not raised");
  chk_irq_off: assert property (!s.ie |-> !emu_irq_out)
    else $error("interrupt raised while disabled");
  chk_next_write: assert property ((wr_take && paddr_in == PDC_OFS_SETUP0) |=>
    (s.next0 == $past(pwdata_in[PDC_CT_NEXT_BIT])))
    else $error("next state bit not stored");
  chk_d0_on: assert property (domain0_on_out)
    else $error("always-on domain turned off");
  chk_go_start: assert property ((go1 && domain1_next_in && s.dom == PDC_ST_OFF) |=>
    (s.dom == PDC_ST_UP) && domain1_power_en_out)
    else $error("go did not start power up");
  chk_go_down: assert property ((go1 && !domain1_next_in && s.dom == PDC_ST_ON) |=>
    (s.dom == PDC_ST_DOWN) ##1 (s.dom == PDC_ST_OFF))
    else $error("go did not power down");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  chk_ready_wait: assert property ((acc_phase && !s.pready) |=> pready_out)
    else $error("access phase not answered");
  chk_slverr_pair: assert property (pslverr_out |-> pready_out)
    else $error("error flag without ready");

  // Status flags after reset and per state
  chk_emu_rst: assert property ($rose(rst_n_in) |-> (!s.emu && !s.irq))
    else $error("emulation flag set after reset");
  chk_por_off: assert property ((s.dom == PDC_ST_OFF) |-> (!domain1_por_n_out && !s.domain_reset_complete))
    else $error("reset released while domain off");
  chk_por_good: assert property ((s.dom == PDC_ST_GOOD) |-> (s.por && !s.domain_reset_complete))
    else $error("reset state wrong while good");
  chk_done_por: assert property (!s.por |-> !s.domain_reset_complete)
    else $error("reset done while reset asserted");
  chk_code_on: assert property ((s.dom == PDC_ST_ON) |->
    (status_word[PDC_ST_CODE_MSB:PDC_ST_CODE_LSB] == PDC_CODE_ON))
    else $error("on state code wrong");
  chk_code_off: assert property ((s.dom == PDC_ST_OFF) |->
    (status_word[PDC_ST_CODE_MSB:PDC_ST_CODE_LSB] == PDC_CODE_OFF))
    else $error("off state code wrong");
  chk_code_busy: assert property (busy |-> ((code >= PDC_CODE_UP) && (code <= PDC_CODE_TR_MAX)))
    else $error("transition code out of range");

  // Setup register fields
  chk_wake_write: assert property ((wr_take && (paddr_in == PDC_OFS_SETUP0)) |=>
    (s.wake == $past(pwdata_in[PDC_CT_WAKE_MSB:PDC_CT_WAKE_LSB])))
    else $error("wake delay not stored");
  chk_wake_hold: assert property (!(wr_take && (paddr_in == PDC_OFS_SETUP0)) |=>
    $stable(s.wake))
    else $error("wake delay changed without write");
  chk_mode_write: assert property ((wr_take && (paddr_in == PDC_OFS_SETUP0)) |=>
    (s.mode == PDC_MODE_ON))
    else $error("mode write took a reserved code");
  chk_ie_write: assert property ((wr_take && (paddr_in == PDC_OFS_SETUP0)) |=>
    (s.ie == $past(pwdata_in[PDC_CT_IE_BIT])))
    else $error("interrupt enable not stored");
  chk_ie_hold: assert property (!(wr_take && (paddr_in == PDC_OFS_SETUP0)) |=>
    $stable(s.ie))
    else $error("interrupt enable changed without write");
  chk_next_hold: assert property (!(wr_take && (paddr_in == PDC_OFS_SETUP0)) |=>
    $stable(s.next0))
    else $error("next state bit changed without write");
  chk_d0_next: assert property ((wr_take && (paddr_in == PDC_OFS_SETUP0) &&
    !pwdata_in[PDC_CT_NEXT_BIT]) |=> domain0_on_out)
    else $error("next state write turned domain 0 off");

  // Wake delay counting
  chk_up_load: assert property (((s.dom == PDC_ST_OFF) && go1 && domain1_next_in) |=>
    (s.cnt == $past(s.wake[3:0])))
    else $error("power-on delay not loaded");
  chk_up_count: assert property (((s.dom == PDC_ST_UP) && (s.cnt != 4'h0)) |=>
    ((s.dom == PDC_ST_UP) && (s.cnt == $past(s.cnt) - 4'h1)))
    else $error("power-on delay not counting");
  chk_good_load: assert property (((s.dom == PDC_ST_UP) && (s.cnt == 4'h0)) |=>
    ((s.dom == PDC_ST_GOOD) && (s.cnt == $past(s.wake[7:4]))))
    else $error("access delay not loaded");
  chk_good_count: assert property (((s.dom == PDC_ST_GOOD) && (s.cnt != 4'h0)) |=>
    ((s.dom == PDC_ST_GOOD) && (s.cnt == $past(s.cnt) - 4'h1)))
    else $error("access delay not counting");

  // Transition command, power switch and interrupt
  chk_off_hold: assert property (((s.dom == PDC_ST_OFF) && !(go1 && domain1_next_in)) |=>
    (s.dom == PDC_ST_OFF))
    else $error("domain left off without command");
  chk_on_hold: assert property (((s.dom == PDC_ST_ON) && !(go1 && !domain1_next_in)) |=>
    (s.dom == PDC_ST_ON))
    else $error("domain left on without command");
  chk_go_zero: assert property ((((s.dom == PDC_ST_OFF) || (s.dom == PDC_ST_ON)) && wr_take &&
    (paddr_in == PDC_OFS_GO) && !pwdata_in[PDC_GO_D1_BIT]) |=> $stable(s.dom))
    else $error("zero command moved the domain");
  chk_pwr_on: assert property (((s.dom == PDC_ST_UP) || (s.dom == PDC_ST_GOOD) ||
    (s.dom == PDC_ST_ON)) |-> domain1_power_en_out)
    else $error("power switch off while domain powered");
  chk_pwr_off: assert property ((s.dom == PDC_ST_OFF) |-> !domain1_power_en_out)
    else $error("power switch on while domain off");
  chk_irq_match: assert property (emu_irq_out ==
    (status_word[PDC_ST_EMU_BIT] && setup_word[PDC_CT_IE_BIT]))
    else $error("interrupt differs from flag and enable");

  cov_power_up: cover property ((s.dom == PDC_ST_GOOD) ##1 (s.dom == PDC_ST_ON));
  cov_power_down: cover property ((s.dom == PDC_ST_DOWN) ##1 (s.dom == PDC_ST_OFF));
  cov_irq: cover property ($rose(emu_irq_out));
  cov_bad_addr: cover property (pready_out && pslverr_out);
  cov_long_wake: cover property ((s.dom == PDC_ST_UP) && (s.cnt == 4'hf));

endmodule : pdc_power_domain_status_control

`default_nettype wire

// >>> dv/power_domain_status_control_bench.sv
// Self-checking bench for the power domain status and setup block
`timescale 1ns/1ps
`default_nettype none

module power_domain_status_control_bench;
  import pdc_pkg::*;
  typedef struct {logic [31:0] dat; logic [31:0] msk; logic err;} pdc_note_type;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic emu_override_in = 1'b0;
  logic domain1_next_in = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, domain1_power_en_out, domain1_por_n_out;
  logic domain0_on_out, emu_irq_out;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed = 32'd91;
  logic [7:0] wake;
  logic [3:0] mode;
  pdc_note_type notes[$];
  pdc_note_type nt;

  pdc_power_domain_status_control i_pdc_power_domain_status_control (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .emu_override_in(emu_override_in), .domain1_next_in(domain1_next_in),
    .domain1_power_en_out(domain1_power_en_out), .domain1_por_n_out(domain1_por_n_out),
    .domain0_on_out(domain0_on_out), .emu_irq_out(emu_irq_out));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xorshift

  task automatic print_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // One APB transfer; the expected answer is noted before the request goes out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic [31:0] msk, input logic err);
    notes.push_back('{exp, msk, err});
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wait_cycles(input int k);
    repeat (k) @(posedge clk_in);
  endtask : wait_cycles

  function automatic logic [31:0] setup_word(input logic [7:0] wk, input logic ie, input logic nx);
    return {8'h00, wk, PDC_MODE_ON, 2'b00, ie, 1'b1, 7'h00, nx};
  endfunction : setup_word

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
    if (rst_n_in === 1'b1 && pready_out === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0, "answer with no request");
      end else begin
        nt = notes.pop_front();
        check(prdata_out & nt.msk, nt.dat, "read data");
        check({31'h0, pslverr_out}, {31'h0, nt.err}, "error flag");
      end
    end
  end

  initial begin
    wait_cycles(12);
    rst_n_in <= 1'b1;
    apb(1'b0, PDC_OFS_STATUS1, 32'h0, 32'h0, 32'hffffffff, 1'b0);
    apb(1'b0, PDC_OFS_SETUP0, 32'h0, 32'h001ff101, 32'hffffffff, 1'b0);
    apb(1'b0, 12'h00c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    seed = xorshift(seed);
    wake = {seed[7:4], 1'b1, seed[2:0]};
    mode = (seed[11:8] == 4'hf) ? 4'he : seed[11:8];
    apb(1'b1, PDC_OFS_SETUP0, {8'h0, wake, mode, 2'b11, 1'b1, 1'b0, 7'h7f, 1'b0},
        32'h0, 32'h0, 1'b0);
    apb(1'b0, PDC_OFS_SETUP0, 32'h0, setup_word(wake, 1'b1, 1'b0), 32'hffffffff, 1'b0);
    check({31'h0, domain0_on_out}, 32'h1, "domain 0 on");
    apb(1'b1, PDC_OFS_STATUS1, 32'hffffffff, 32'h0, 32'h0, 1'b0);
    apb(1'b0, PDC_OFS_STATUS1, 32'h0, 32'h0, 32'hffffffff, 1'b0);
    emu_override_in <= 1'b1;
    wait_cycles(3);
    check({31'h0, emu_irq_out}, 32'h1, "irq on");
    apb(1'b0, PDC_OFS_STATUS1, 32'h0, 32'h800, 32'hffffffff, 1'b0);
    apb(1'b1, PDC_OFS_SETUP0, setup_word(wake, 1'b0, 1'b0), 32'h0, 32'h0, 1'b0);
    wait_cycles(2);
    check({31'h0, emu_irq_out}, 32'h0, "irq masked");
    emu_override_in <= 1'b0;
    domain1_next_in <= 1'b1;
    apb(1'b1, PDC_OFS_GO, 32'h2, 32'h0, 32'h0, 1'b0);
    n = 0;
    while (domain1_power_en_out !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    n = 0;
    while (domain1_por_n_out !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    check(n, wake[3:0] + 1, "power on to good");
    wait_cycles(wake[7:4] + 6);
    apb(1'b0, PDC_OFS_STATUS1, 32'h0, 32'h301, 32'hffffffff, 1'b0);
    domain1_next_in <= 1'b0;
    apb(1'b1, PDC_OFS_GO, 32'h2, 32'h0, 32'h0, 1'b0);
    wait_cycles(5);
    check({31'h0, domain1_power_en_out}, 32'h0, "domain 1 off");
    apb(1'b0, PDC_OFS_STATUS1, 32'h0, 32'h0, 32'hffffffff, 1'b0);
    apb(1'b1, PDC_OFS_SETUP0, setup_word(8'hff, 1'b0, 1'b1), 32'h0, 32'h0, 1'b0);
    domain1_next_in <= 1'b1;
    apb(1'b1, PDC_OFS_GO, 32'h2, 32'h0, 32'h0, 1'b0);
    apb(1'b0, PDC_OFS_STATUS1, 32'h0, 32'h010, 32'hffffffff, 1'b0);
    wait_cycles(40);
    apb(1'b0, PDC_OFS_STATUS1, 32'h0, 32'h301, 32'hffffffff, 1'b0);
    wait_cycles(3);
    print_verdict();
  end
endmodule : power_domain_status_control_bench

`default_nettype wire
